// ---- rtl/pmc_pkg.sv ----
// package for the power-management capability word block
package pmc_pkg;

   // ---------------------------------------------------------------
   // address and layout
   // ---------------------------------------------------------------
   localparam logic [7:0]  PMC_WORD_OFFSET    = 8'h50;
   localparam logic [31:0] PMC_FIXED_PATTERN  = 32'h40000001;
   localparam logic [7:0]  PMC_NEXT_PTR       = 8'h00;
   localparam logic [7:0]  PMC_CAP_ID         = 8'h01;
   localparam logic [2:0]  PMC_AUX_NONE       = 3'h0;
   localparam int          PMC_D3COLD_POS     = 31;
   localparam int          PMC_D3HOT_POS      = 30;
   localparam int          PMC_D2WAKE_POS     = 29;
   localparam int          PMC_D1WAKE_POS     = 28;
   localparam int          PMC_D0WAKE_POS     = 27;
   localparam int          PMC_D2CAP_POS      = 26;
   localparam int          PMC_D1CAP_POS      = 25;
   localparam int          PMC_AUX_LSB        = 22;
   localparam int          PMC_DSI_POS        = 21;
   localparam int          PMC_RSVD_POS       = 20;
   localparam int          PMC_CLK_POS        = 19;
   localparam int          PMC_VER_LSB        = 16;
   localparam int          PMC_NEXT_LSB       = 8;
   localparam int          PMC_ID_LSB         = 0;
   localparam logic [31:0] PMC_RDATA_RESET    = 32'h00000000;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       d3cold_wake;
      logic       d2_wake;
      logic       d1_wake;
      logic       d2_capable;
      logic       eeprom_d1_capable_bit;
      logic [2:0] aux_current;
      logic       eeprom_special_init_bit;
      logic       eeprom_wake_needs_clock_bit;
      logic [2:0] eeprom_pm_revision_bits;
   } pmc_eeprom_t;

   localparam pmc_eeprom_t PMC_EEPROM_RESET = '0;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pmc_cfg_req_t;

   typedef struct packed {
      pmc_eeprom_t ee;
      logic [31:0] rdata;
      logic        ack;
   } pmc_state_t;

endpackage

// ---- rtl/pmc_capability_word.sv ----
// power-management capability word, read-only in configuration space
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: bit 25 reports the loaded D1-capable EEPROM bit.
// RULE2: bits 24..22 aux current; read zero when cold-D3 wake unsupported.
// RULE3: bit 21 reports the loaded special-initialisation EEPROM bit.
// RULE4: bit 19 reports whether wake generation needs the PCI clock.
// RULE5: bits 18..16 report the three loaded PM revision bits.
// RULE6: bits 15..8 read constant zero, last capability in the chain.
// RULE7: bits 7..0 read constant one, the power-management identifier.
// RULE8: after reset, fixed pattern combined with EEPROM fields.
// RULE9: configuration writes change nothing, whatever data or byte enables.
// RULE10: reserved bit 20 always reads zero.
// RULE11: bit 30, hot-D3 wake support, is constantly one.
// RULE12: upper half always equals all 16 bits of the mirror register.
module pmc_capability_word (
   input  wire logic                  core_clk_i,    // 100 MHz core clock
   input  wire logic                  srst_i,        // sync reset, high
   input  wire logic                  ee_load_i,     // pulse: capture eeprom bits
   input  wire pmc_pkg::pmc_eeprom_t  ee_bits_i,     // eeprom configuration bits
   input  wire pmc_pkg::pmc_cfg_req_t cfg_req_i,     // config access request
   output logic [31:0]                cfg_rdata_o,   // read data, registered
   output logic                       cfg_ack_o,     // one-cycle answer pulse
   output logic [31:0]                pm_capability_word_o,   // live word
   output logic [15:0]                pm_capabilities_mirror_o // mirror of word upper half
);
   import pmc_pkg::*;

   // ---------------------------------------------------------------
   // word assembly
   // ---------------------------------------------------------------
   function automatic logic [31:0] build_word(input pmc_eeprom_t e);
      logic [31:0] w;
      w = PMC_FIXED_PATTERN;                                           // [RULE8] [RULE11]
      w[PMC_D3COLD_POS] = e.d3cold_wake;
      w[PMC_D2WAKE_POS] = e.d2_wake;
      w[PMC_D1WAKE_POS] = e.d1_wake;
      w[PMC_D2CAP_POS]  = e.d2_capable;
      w[PMC_D1CAP_POS]  = e.eeprom_d1_capable_bit;                     // [RULE1]
      w[PMC_AUX_LSB +: 3] = e.d3cold_wake ? e.aux_current : PMC_AUX_NONE; // [RULE2]
      w[PMC_DSI_POS]    = e.eeprom_special_init_bit;                   // [RULE3]
      w[PMC_RSVD_POS]   = 1'b0;                                        // [RULE10]
      w[PMC_CLK_POS]    = e.eeprom_wake_needs_clock_bit;               // [RULE4]
      w[PMC_VER_LSB +: 3] = e.eeprom_pm_revision_bits;                 // [RULE5]
      w[PMC_NEXT_LSB +: 8] = PMC_NEXT_PTR;                             // [RULE6]
      w[PMC_ID_LSB +: 8]   = PMC_CAP_ID;                               // [RULE7]
      return w;
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pmc_state_t st;
   pmc_state_t next_st;
   logic        hit;
   logic        take;
   logic [31:0] word;

   assign word = build_word(st.ee);
   assign hit  = (cfg_req_i.addr == PMC_WORD_OFFSET);
   // a request held through its answer edge must not be taken twice
   assign take = hit && (cfg_req_i.rd || cfg_req_i.wr) && !st.ack;

   always_comb begin
      next_st = st;
      next_st.ack = 1'b0;
      // eeprom loader is same-clock logic, so no synchroniser
      if (ee_load_i) begin
         next_st.ee = ee_bits_i;
      end
      // writes are acknowledged but never touch the stored bits
      if (take) begin                                                  // [RULE9]
         next_st.ack = 1'b1;
      end
      if (take && cfg_req_i.rd) begin
         next_st.rdata = word;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st.ee    <= PMC_EEPROM_RESET;                                 // [RULE8]
         st.rdata <= PMC_RDATA_RESET;
         st.ack   <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign cfg_rdata_o              = st.rdata;
   assign cfg_ack_o                = st.ack;
   assign pm_capability_word_o     = word;
   assign pm_capabilities_mirror_o = word[31:16];                      // [RULE12]

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_D1_BIT: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE1]
      ee_load_i |=> word[PMC_D1CAP_POS] == $past(ee_bits_i.eeprom_d1_capable_bit))
      else $error("d1 capable bit not taken from eeprom");

   AST_AUX_ZERO: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE2]
      !word[PMC_D3COLD_POS] |-> word[PMC_AUX_LSB +: 3] == PMC_AUX_NONE)
      else $error("aux current nonzero without cold wake");

   AST_DSI_BIT: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE3]
      ee_load_i |=> word[PMC_DSI_POS] == $past(ee_bits_i.eeprom_special_init_bit))
      else $error("special init bit wrong");

   AST_CLK_BIT: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE4]
      ee_load_i |=> word[PMC_CLK_POS] == $past(ee_bits_i.eeprom_wake_needs_clock_bit))
      else $error("clock need bit wrong");

   AST_VER_BITS: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE5]
      ee_load_i |=> word[PMC_VER_LSB +: 3] == $past(ee_bits_i.eeprom_pm_revision_bits))
      else $error("revision bits wrong");

   AST_READ_CONST: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE6]
      (cfg_req_i.rd && hit && !cfg_ack_o) |=> cfg_ack_o
         && cfg_rdata_o[15:0] == {PMC_NEXT_PTR, PMC_CAP_ID})
      else $error("read low half not next-zero id-one");

   AST_RESET_WORD: assert property (@(posedge core_clk_i) // [RULE8]
      $past(srst_i) |-> word == PMC_FIXED_PATTERN)
      else $error("word after reset not fixed pattern");

   AST_WRITE_IGNORED: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE9]
      (cfg_req_i.wr && !ee_load_i) |=> $stable(word))
      else $error("write altered the word");

   AST_RSVD_HOT: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE10]
      !word[PMC_RSVD_POS] && word[PMC_D3HOT_POS] && !word[PMC_D0WAKE_POS])
      else $error("reserved or hot-d3 bit wrong");

   AST_MIRROR: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE12]
      (cfg_req_i.rd && hit && !cfg_ack_o) |=> cfg_rdata_o[31:16] == pm_capabilities_mirror_o
         || $past(ee_load_i))
      else $error("mirror differs from read upper half");

   AST_ID_BYTE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE7]
      word[PMC_ID_LSB +: 8] == PMC_CAP_ID)
      else $error("capability id byte wrong");

   AST_NEXT_BYTE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE6]
      word[PMC_NEXT_LSB +: 8] == PMC_NEXT_PTR)
      else $error("next item pointer not zero");

   AST_HOT_WAKE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE11]
      word[PMC_D3HOT_POS])
      else $error("hot-d3 wake bit not one");

   AST_RSVD_ZERO: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE10]
      !pm_capability_word_o[PMC_RSVD_POS])
      else $error("reserved bit not zero");

   AST_D0_WAKE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE8]
      !pm_capability_word_o[PMC_D0WAKE_POS])
      else $error("d0 wake bit not zero");

   AST_MIRROR_LIVE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE12]
      pm_capabilities_mirror_o == pm_capability_word_o[31:16])
      else $error("mirror output differs from word upper half");

   AST_MIRROR_RESET: assert property (@(posedge core_clk_i) // [RULE12]
      $past(srst_i) |-> pm_capabilities_mirror_o == PMC_FIXED_PATTERN[31:16])
      else $error("mirror after reset wrong");

   AST_WAKE_BITS: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE8]
      ee_load_i |=> word[PMC_D3COLD_POS] == $past(ee_bits_i.d3cold_wake)
         && word[PMC_D2WAKE_POS] == $past(ee_bits_i.d2_wake)
         && word[PMC_D1WAKE_POS] == $past(ee_bits_i.d1_wake)
         && word[PMC_D2CAP_POS] == $past(ee_bits_i.d2_capable))
      else $error("loaded wake support bits wrong");

   AST_AUX_BITS: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE2]
      (ee_load_i && ee_bits_i.d3cold_wake) |=> word[PMC_AUX_LSB +: 3]
         == $past(ee_bits_i.aux_current))
      else $error("aux current not taken from eeprom");

   AST_HOLD_NO_LOAD: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE9]
      !ee_load_i |=> $stable(pm_capability_word_o))
      else $error("word changed without a load");

   AST_READ_WORD: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE8]
      (cfg_req_i.rd && hit && !cfg_ack_o) |=> cfg_rdata_o == $past(pm_capability_word_o))
      else $error("read data differs from word");

   AST_WRITE_ACK: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE9]
      (cfg_req_i.wr && !cfg_req_i.rd && hit && !cfg_ack_o) |=> cfg_ack_o
         && $stable(cfg_rdata_o))
      else $error("write not answered or read data moved");

   AST_RDATA_HOLD: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE9]
      (!(cfg_req_i.rd && hit) || cfg_ack_o) |=> $stable(cfg_rdata_o))
      else $error("read data changed without a read");

   AST_ACK_PULSE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE9]
      cfg_ack_o |=> !cfg_ack_o)
      else $error("answer longer than one cycle");

   AST_NO_STRAY_ACK: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RULE9]
      (!hit || !(cfg_req_i.rd || cfg_req_i.wr) || cfg_ack_o) |=> !cfg_ack_o)
      else $error("answer without a request");

   AST_RESET_OUTS: assert property (@(posedge core_clk_i) // [RULE8]
      $past(srst_i) |-> !cfg_ack_o && cfg_rdata_o == PMC_RDATA_RESET)
      else $error("bus outputs after reset wrong");

   // ---------------------------------------------------------------
   // cover points
   // ---------------------------------------------------------------
   COV_READ: cover property (@(posedge core_clk_i) disable iff (srst_i)
      cfg_req_i.rd && hit && !cfg_ack_o ##1 cfg_ack_o);
   COV_WRITE: cover property (@(posedge core_clk_i) disable iff (srst_i)
      cfg_req_i.wr && hit && cfg_req_i.be == 4'hF);
   COV_LOAD_COLD: cover property (@(posedge core_clk_i) disable iff (srst_i)
      ee_load_i && ee_bits_i.d3cold_wake && ee_bits_i.aux_current != PMC_AUX_NONE);
   COV_HELD_READ: cover property (@(posedge core_clk_i) disable iff (srst_i)
      cfg_ack_o && cfg_req_i.rd && hit);
   COV_UNMAPPED: cover property (@(posedge core_clk_i) disable iff (srst_i)
      (cfg_req_i.rd || cfg_req_i.wr) && !hit);

endmodule

`default_nettype wire

// ---- bench/pmc_host_model.sv ----
// host-side model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
   input  wire logic                 core_clk_i,  // core clock
   input  wire logic                 cfg_ack_i,   // answer pulse
   input  wire logic [31:0]          cfg_rdata_i, // read data
   output var  pmc_pkg::pmc_cfg_req_t cfg_req_o   // request
);
   import pmc_pkg::*;
   initial cfg_req_o = '0;
   // request stands until the edge that shows the answer
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic ok, output logic [31:0] rd);
      ok = 1'b0;
      rd = 32'h0;
      @(negedge core_clk_i);
      cfg_req_o = '{rd: ~wr, wr: wr, addr: a, be: be, wdata: wd};
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge core_clk_i);
         if (cfg_ack_i === 1'b1) begin
            ok = 1'b1;
            rd = cfg_rdata_i;
         end
      end
      @(negedge core_clk_i);
      // released bus shows no stale value
      cfg_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: ~wd};
   endtask
endmodule
`default_nettype wire

// ---- bench/pmc_capability_word_tb_top.sv ----
// testbench for the power-management capability word
`timescale 1ns/1ps
`default_nettype none
module pmc_capability_word_tb_top;
   import pmc_pkg::*;
   logic core_clk_i = 1'b0, srst_i = 1'b1, ee_load_i = 1'b0, ack, ok;
   pmc_eeprom_t ee_bits_i = '0;
   pmc_cfg_req_t req;
   logic [31:0] rdata, word, got;
   logic [15:0] mirror;
   int fails = 0, tests_run = 0;
   initial forever #5 core_clk_i = ~core_clk_i;
   pmc_capability_word dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .ee_load_i(ee_load_i),
      .ee_bits_i(ee_bits_i), .cfg_req_i(req), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
      .pm_capability_word_o(word), .pm_capabilities_mirror_o(mirror));
   pmc_host_model host (.core_clk_i(core_clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata),
      .cfg_req_o(req));
   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         $display("unexpected at %0t: got %08h expected %08h", $time, g, e);
         fails++;
      end
   endtask
   function automatic logic [31:0] exp_word(input pmc_eeprom_t v);
      logic [31:0] w;
      w = 32'h40000001;
      w[31] = v.d3cold_wake;
      w[29] = v.d2_wake;
      w[28] = v.d1_wake;
      w[26] = v.d2_capable;
      w[25] = v.eeprom_d1_capable_bit;
      w[24:22] = v.d3cold_wake ? v.aux_current : 3'h0;
      w[21] = v.eeprom_special_init_bit;
      w[19] = v.eeprom_wake_needs_clock_bit;
      w[18:16] = v.eeprom_pm_revision_bits;
      return w;
   endfunction
   // read the word, judge it and its mirror
   task automatic read_chk(input logic [31:0] e);
      host.xfer(1'b0, 8'h50, 32'h0, 4'hF, ok, got);
      chk({31'h0, ok}, 32'h1);
      chk(got, e);
      chk(word, e);
      chk({16'h0, mirror}, {16'h0, e[31:16]});
   endtask
   task automatic do_reset();
      @(negedge core_clk_i);
      srst_i = 1'b1;
      repeat (8) @(negedge core_clk_i);
      srst_i = 1'b0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_loads();
      pmc_eeprom_t tbl [5] = '{13'h1FFF, 13'h0FFF, 13'h1000, 13'h0100, 13'h0055};
      foreach (tbl[i]) begin
         @(negedge core_clk_i);
         ee_bits_i = tbl[i];
         ee_load_i = 1'b1;
         @(negedge core_clk_i);
         ee_load_i = 1'b0;
         ee_bits_i = ~tbl[i];
         read_chk(exp_word(tbl[i]));
      end
      $display("loads test done");
   endtask
   task automatic t_writes();
      host.xfer(1'b1, 8'h50, 32'hFFFFFFFF, 4'hF, ok, got);
      chk({31'h0, ok}, 32'h1);
      host.xfer(1'b1, 8'h50, 32'h00000000, 4'h1, ok, got);
      chk({31'h0, ok}, 32'h1);
      read_chk(exp_word(13'h0055));
      $display("writes test done");
   endtask
   task automatic t_unmapped();
      host.xfer(1'b0, 8'h54, 32'h0, 4'hF, ok, got);
      chk({31'h0, ok}, 32'h0);
      chk(rdata, exp_word(13'h0055));
      $display("unmapped test done");
   endtask
   task automatic t_reset();
      do_reset();
      read_chk(32'h40000001);
      $display("reset test done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      do_reset();
      t_reset();
      t_loads();
      t_writes();
      t_unmapped();
      t_reset();
      report_and_stop();
   end
   initial begin
      #200000;
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
